// ===== wdpc_core.sv
// Functional notes
// [RULE1] first pre-clear with partner done zeroes watchdog counter
// [RULE2] completed pair clears power-down and timeout; other flags kept
// [RULE3] lone first pre-clear only records itself; nothing else changes
// [RULE4] second pre-clear with partner done zeroes counter, clears flags
// [RULE5] lone second pre-clear only records itself; nothing else changes
// [RULE6] complement instruction inverts addressed byte, writes same place
// [RULE7] either order accepted; records cleared after a completed pair
`timescale 1ns/1ps
`default_nettype none
module wdpc_core
   import wdpc_pkg::*;
#(
   parameter int DATA_W = WDPC_DATA_W,
   parameter int ADDR_W = WDPC_ADDR_W,
   parameter int WDT_W  = WDPC_WDT_W
)(
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   input  wire wdpc_op_t          op_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] mem_rdata_i,
   input  wire logic              wdt_tick_i,
   input  wire logic              halt_i,
   input  wire wdpc_flags_t       flags_i,
   output logic                   wdt_clear_o,
   output logic [WDT_W-1:0]       wdt_count_o,
   output wdpc_flags_t            flags_o,
   output logic                   mem_we_o,
   output logic [ADDR_W-1:0]      mem_addr_o,
   output logic [DATA_W-1:0]      mem_wdata_o,
   output logic                   first_seen_o,
   output logic                   second_seen_o
);

   // ==========================================================
   // internal state
   // ==========================================================
   logic                  is_first;
   logic                  is_second;
   logic                  is_cpl;
   logic                  pair_clear;
   logic                  wdt_wrap;
   logic [DATA_W-1:0]     cpl_byte;

   logic [WDT_W-1:0]      wdt_reg;
   logic [WDT_W-1:0]      wdt_next;
   logic                  to_reg;
   logic                  to_next;
   logic                  pdf_reg;
   logic                  pdf_next;

   logic                  we_reg;
   logic                  we_next;
   logic [ADDR_W-1:0]     addr_reg;
   logic [ADDR_W-1:0]     addr_next;
   logic [DATA_W-1:0]     wdata_reg;
   logic [DATA_W-1:0]     wdata_next;

   // ==========================================================
   // instruction decode
   // ==========================================================
   always_comb begin
      is_first  = 1'h0;
      is_second = 1'h0;
      is_cpl    = 1'h0;
      case (op_i)
         WDPC_OP_FIRST: begin
            is_first = 1'h1;
         end
         WDPC_OP_SECOND: begin
            is_second = 1'h1;
         end
         WDPC_OP_CPL: begin
            is_cpl = 1'h1;
         end
         default: begin
            is_cpl = 1'h0;
         end
      endcase
   end

   // ==========================================================
   // pre-clear pairing
   // ==========================================================
   wdpc_pair_track u_pair (
      .clk_sys_i     (clk_sys_i),
      .resetn_i      (resetn_i),
      .first_i       (is_first),
      .second_i      (is_second),
      .clear_o       (pair_clear),
      .first_seen_o  (first_seen_o),
      .second_seen_o (second_seen_o)
   );

   // ==========================================================
   // watchdog counter
   // ==========================================================
   assign wdt_wrap = wdt_tick_i && (&wdt_reg);

   always_comb begin
      wdt_next = wdt_reg;
      // a completed pair beats a tick in the same cycle
      if (pair_clear) begin
         wdt_next = WDT_W'(WDPC_WDT_CLEAR);       // [RULE1] [RULE4]
      end else if (wdt_tick_i) begin
         wdt_next = wdt_reg + WDT_W'(1'h1);
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wdt_reg <= WDT_W'(WDPC_WDT_CLEAR);
      end else begin
         wdt_reg <= wdt_next;
      end
   end

   // ==========================================================
   // timeout flag
   // ==========================================================
   always_comb begin
      to_next = to_reg;
      if (pair_clear || halt_i) begin
         to_next = WDPC_FLAG_CLEAR;               // [RULE2] [RULE4]
      end
      // a wrap wins over any clear in the same cycle
      if (wdt_wrap) begin
         to_next = 1'h1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         to_reg <= WDPC_FLAG_CLEAR;
      end else begin
         to_reg <= to_next;
      end
   end

   // ==========================================================
   // power-down flag
   // ==========================================================
   always_comb begin
      pdf_next = pdf_reg;
      if (pair_clear) begin
         pdf_next = WDPC_FLAG_CLEAR;              // [RULE2]
      end
      // a halt wins over a pair clear in the same cycle
      if (halt_i) begin
         pdf_next = 1'h1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pdf_reg <= WDPC_FLAG_CLEAR;
      end else begin
         pdf_reg <= pdf_next;
      end
   end

   // ==========================================================
   // per-bit complement of the operand
   // ==========================================================
   for (genvar bit_idx = 0; bit_idx < DATA_W; bit_idx++) begin : g_cpl_bit
      assign cpl_byte[bit_idx] = ~mem_rdata_i[bit_idx];  // [RULE6]
   end

   // ==========================================================
   // write-back strobe
   // ==========================================================
   always_comb begin
      we_next = is_cpl;                           // [RULE6]
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         we_reg <= 1'h0;
      end else begin
         we_reg <= we_next;
      end
   end

   // ==========================================================
   // write-back address and data
   // ==========================================================
   always_comb begin
      addr_next  = addr_reg;
      wdata_next = wdata_reg;
      if (is_cpl) begin
         addr_next  = addr_i;                     // [RULE6]
         wdata_next = cpl_byte;                   // [RULE6]
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         addr_reg  <= '0;
         wdata_reg <= '0;
      end else begin
         addr_reg  <= addr_next;
         wdata_reg <= wdata_next;
      end
   end

   // ==========================================================
   // flag outputs
   // ==========================================================
   always_comb begin
      flags_o                 = flags_i;          // [RULE2]
      flags_o.timeout_flag    = to_reg;
      flags_o.power_down_flag = pdf_reg;
   end

   // ==========================================================
   // watchdog and write-back outputs
   // ==========================================================
   assign wdt_clear_o = pair_clear;
   assign wdt_count_o = wdt_reg;
   assign mem_we_o    = we_reg;
   assign mem_addr_o  = addr_reg;
   assign mem_wdata_o = wdata_reg;

endmodule : wdpc_core
`default_nettype wire

// ===== wdpc_pkg.sv
package wdpc_pkg;

   // ==========================================================
   // widths and reset values
   // ==========================================================
   localparam int          WDPC_DATA_W     = 8;
   localparam int          WDPC_ADDR_W     = 8;
   localparam int          WDPC_WDT_W      = 8;
   localparam logic [7:0]  WDPC_WDT_CLEAR  = 8'h00;
   localparam logic        WDPC_FLAG_CLEAR = 1'b0;
   localparam logic        WDPC_REC_RESET  = 1'b0;

   // ==========================================================
   // opcode selector
   // ==========================================================
   typedef enum logic [1:0] {
      WDPC_OP_NONE   = 2'h0,
      WDPC_OP_FIRST  = 2'h1,
      WDPC_OP_SECOND = 2'h3,
      WDPC_OP_CPL    = 2'h2
   } wdpc_op_t;

   // ==========================================================
   // status flag bundle
   // ==========================================================
   typedef struct packed {
      logic timeout_flag;
      logic power_down_flag;
      logic overflow_flag;
      logic zero_flag;
      logic aux_carry_flag;
      logic carry_flag;
   } wdpc_flags_t;

endpackage : wdpc_pkg

// ===== wdpc_pair_track.sv
`timescale 1ns/1ps
`default_nettype none
module wdpc_pair_track
   import wdpc_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   input  wire logic first_i,
   input  wire logic second_i,
   output logic      clear_o,
   output logic      first_seen_o,
   output logic      second_seen_o
);

   logic first_reg;
   logic first_next;
   logic second_reg;
   logic second_next;

   // ==========================================================
   // pair completion
   // ==========================================================
   always_comb begin
      clear_o     = (first_i && second_reg) ||
                    (second_i && first_reg);      // [RULE7]
      first_next  = first_reg;
      second_next = second_reg;
      if (clear_o) begin
         first_next  = 1'b0;                      // [RULE7]
         second_next = 1'b0;
      end else if (first_i) begin
         first_next  = 1'b1;                      // [RULE3]
      end else if (second_i) begin
         second_next = 1'b1;                      // [RULE5]
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         first_reg  <= WDPC_REC_RESET;
         second_reg <= WDPC_REC_RESET;
      end else begin
         first_reg  <= first_next;
         second_reg <= second_next;
      end
   end

   assign first_seen_o  = first_reg;
   assign second_seen_o = second_reg;

endmodule : wdpc_pair_track
`default_nettype wire

// ===== wdpc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module wdpc_checker
   import wdpc_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        resetn_i,
   input wire wdpc_op_t    op_i,
   input wire logic [7:0]  addr_i,
   input wire logic [7:0]  mem_rdata_i,
   input wire logic        wdt_tick_i,
   input wire logic        halt_i,
   input wire wdpc_flags_t flags_i,
   input wire logic        wdt_clear_o,
   input wire logic [7:0]  wdt_count_o,
   input wire wdpc_flags_t flags_o,
   input wire logic        mem_we_o,
   input wire logic [7:0]  mem_addr_o,
   input wire logic [7:0]  mem_wdata_o,
   input wire logic        first_seen_o,
   input wire logic        second_seen_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   // ========
   // pair and complement
   // ========
   sequence s_done;
      wdt_clear_o ##1 (wdt_count_o == WDPC_WDT_CLEAR &&
         flags_o.timeout_flag ==
            ($past(wdt_tick_i) && (&$past(wdt_count_o))) &&
         flags_o.power_down_flag == $past(halt_i));
   endsequence
   sequence s_free;
      wdt_clear_o ##1 !(first_seen_o || second_seen_o);
   endsequence
   AST_PAIR_BY_FIRST: assert property (op_i == WDPC_OP_FIRST &&
      second_seen_o |-> s_done) else $error("pair by first failed");
   AST_PAIR_BY_SECOND: assert property (op_i == WDPC_OP_SECOND &&
      first_seen_o |-> s_done) else $error("pair by second failed");
   AST_KEEP_FLAGS: assert property (flags_o[3:0] == flags_i[3:0])
      else $error("core flags altered");
   AST_LONE_FIRST: assert property (op_i == WDPC_OP_FIRST &&
      !second_seen_o |-> !wdt_clear_o ##1 first_seen_o)
      else $error("lone first misbehaved");
   AST_LONE_SECOND: assert property (op_i == WDPC_OP_SECOND &&
      !first_seen_o |-> !wdt_clear_o ##1 second_seen_o)
      else $error("lone second misbehaved");
   AST_RECS_FREED: assert property (wdt_clear_o |-> s_free)
      else $error("records kept after pair");
   AST_COMPLEMENT: assert property (op_i == WDPC_OP_CPL |=> mem_we_o &&
      mem_wdata_o == ~$past(mem_rdata_i) && mem_addr_o == $past(addr_i))
      else $error("complement write wrong");
endmodule : wdpc_checker
`default_nettype wire

// ===== tb_wdpc_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_wdpc_core;
   import wdpc_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        resetn_i = 1'b0;
   wdpc_op_t    op_i = WDPC_OP_NONE;
   logic [7:0]  addr_i = 8'h00;
   logic [7:0]  mem_rdata_i = 8'h00;
   logic        wdt_tick_i = 1'b0;
   logic        halt_i = 1'b0;
   wdpc_flags_t flags_i = 6'h0A;
   logic        wdt_clear_o, mem_we_o, first_seen_o, second_seen_o;
   logic [7:0]  wdt_count_o, mem_addr_o, mem_wdata_o;
   wdpc_flags_t flags_o;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   wdpc_core wdpc_core_inst (.clk_sys_i, .resetn_i, .op_i, .addr_i,
      .mem_rdata_i, .wdt_tick_i, .halt_i, .flags_i, .wdt_clear_o,
      .wdt_count_o, .flags_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
      .first_seen_o, .second_seen_o);
   // ========
   // tasks
   // ========
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic issue(input wdpc_op_t op);
      @(posedge clk_sys_i);
      op_i <= op;
      @(negedge clk_sys_i);
   endtask : issue
   task automatic pair(input wdpc_op_t a, input wdpc_op_t b);
      @(posedge clk_sys_i);
      halt_i <= 1'b1;
      @(posedge clk_sys_i);
      halt_i <= 1'b0;
      wdt_tick_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      wdt_tick_i <= 1'b0;
      issue(a);
      chk({7'h00, wdt_clear_o}, 8'h00);
      issue(a);
      issue(b);
      chk(wdt_count_o, 8'h03);
      chk({2'h0, flags_o}, 8'h1A);
      chk({6'h00, first_seen_o, second_seen_o},
         (a == WDPC_OP_FIRST) ? 8'h02 : 8'h01);
      chk({7'h00, wdt_clear_o}, 8'h01);
      issue(WDPC_OP_NONE);
      chk(wdt_count_o, 8'h00);
      chk({2'h0, flags_o}, 8'h0A);
      chk({6'h00, first_seen_o, second_seen_o}, 8'h00);
   endtask : pair
   task automatic complement_memory;
      @(posedge clk_sys_i);
      addr_i <= 8'h5A;
      mem_rdata_i <= 8'hC3;
      issue(WDPC_OP_CPL);
      issue(WDPC_OP_NONE);
      chk({7'h00, mem_we_o}, 8'h01);
      chk(mem_addr_o, 8'h5A);
      chk(mem_wdata_o, 8'h3C);
      issue(WDPC_OP_NONE);
      chk({7'h00, mem_we_o}, 8'h00);
   endtask : complement_memory
   task automatic wrap;
      @(posedge clk_sys_i);
      wdt_tick_i <= 1'b1;
      repeat (258) @(posedge clk_sys_i);
      wdt_tick_i <= 1'b0;
      issue(WDPC_OP_FIRST);
      issue(WDPC_OP_SECOND);
      chk(wdt_count_o, 8'h02);
      chk({2'h0, flags_o}, 8'h2A);
      chk({7'h00, wdt_clear_o}, 8'h01);
      issue(WDPC_OP_NONE);
      chk(wdt_count_o, 8'h00);
      chk({2'h0, flags_o}, 8'h0A);
   endtask : wrap
   task automatic conclude;
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      pair(WDPC_OP_FIRST, WDPC_OP_SECOND);
      pair(WDPC_OP_SECOND, WDPC_OP_FIRST);
      complement_memory();
      wrap();
      conclude();
   end
endmodule : tb_wdpc_core
bind wdpc_core wdpc_checker wdpc_checker_inst (.clk_sys_i, .resetn_i,
   .op_i, .addr_i, .mem_rdata_i, .wdt_tick_i, .halt_i, .flags_i,
   .wdt_clear_o, .wdt_count_o,
   .flags_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .first_seen_o,
   .second_seen_o);
`default_nettype wire
